// [lpm_irq_defs.vh]
`ifndef LPM_IRQ_DEFS_VH
`define LPM_IRQ_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PWR_CTRL_IDX   10'h087
`define EXTCFG_IDX     10'h088
`define IRQ_EN_IDX     10'h0A8
`define PRIO_HI_IDX    10'h0B7
`define PRIO_LO_IDX    10'h0B8
`define STATUS_IDX     10'h0C0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWR_IDLE_BIT   0
`define PWR_DOWN_BIT   1
`define EN_GLOBAL_BIT  7
`define EXT0_SRC       0
`define EXT1_SRC       2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PWR_CTRL_RST   2'h0
`define IRQ_EN_RST     8'h00
`define PRIO_RST       6'h00
`define EXTCFG_RST     2'h0

`endif

// [irq_arbiter.v]
`timescale 1ns/1ps

module irq_arbiter #(
  parameter N = 6
) (
  input  wire [N-1:0] req,
  input  wire [N-1:0] lvl_upper,
  input  wire [N-1:0] lvl_lower,
  output reg          found,
  output reg  [2:0]   idx,
  output reg  [1:0]   level
);

  integer l;
  integer s;

  // ----------------------------------------
  // Later hits overwrite: highest level, then lowest index
  // ----------------------------------------
  always @* begin
    found = 1'b0;
    idx   = 3'h0;
    level = 2'h0;
    for (l = 0; l < 4; l = l + 1) begin
      for (s = N - 1; s >= 0; s = s - 1) begin
        if (req[s] && ({lvl_upper[s], lvl_lower[s]} == l[1:0])) begin
          found = 1'b1;
          idx   = s[2:0];
          level = l[1:0];
        end
      end
    end
  end

endmodule // irq_arbiter

// [ext_irq_detect.v]
`timescale 1ns/1ps

module ext_irq_detect (
  input  wire core_clk,
  input  wire reset,
  input  wire pin_n,
  input  wire edge_mode,
  input  wire capture_en,
  input  wire clear,
  output wire req,
  output wire low,
  output wire rise
);

  reg pin_prev_reg;
  reg flag_reg;
  wire fall;
  wire flag_next;

  assign fall      = pin_prev_reg & ~pin_n;
  assign rise      = ~pin_prev_reg & pin_n;
  assign low       = ~pin_n;
  // Set beats clear so a fall in the ack cycle is kept
  assign flag_next = (fall & capture_en) | (flag_reg & ~clear);
  assign req       = flag_reg | (~edge_mode & ~pin_n);

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_prev_reg <= 1'b1;
      flag_reg     <= 1'b0;
    end else begin
      pin_prev_reg <= pin_n;
      flag_reg     <= flag_next;
    end
  end

endmodule // ext_irq_detect

// [lpm_irq_ctrl.v]
// Overview of operation
// - Per-source enables plus one global gate
// - Two-bit level, upper and lower bits
// - Preempt only by strictly higher level
// - Higher level wins among simultaneous requests
// - Idle bit write enters idle afterwards
// - Idle stops CPU clock, peripherals run
// - Idle holds state, strobes driven high
// - Enabled interrupt clears idle and is served
// - Power-down stops oscillator, registers kept
// - Only reset or enabled external pins wake
// - Pin low restarts oscillator, release completes
// - Either pin restarts, first release completes
// - Resume after power-down entry instruction
// - Interrupt exit clears only power control bits
// - Both bits set follows power-down exit
// - Strobes high idle, low power-down; ports
// - Port 0 drives only zeros when held
// - Power control register bits, index 87h
`timescale 1ns/1ps
`include "lpm_irq_defs.vh"

module lpm_irq_ctrl (
  input  wire        core_clk,
  input  wire        reset,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Interrupt sources
  input  wire        ext_irq_zero,
  input  wire        ext_irq_one,
  input  wire [3:0]  periph_irq,
  // CPU side
  output reg         irq_valid,
  output reg  [2:0]  irq_vector,
  input  wire        irq_ack,
  input  wire        return_from_isr,
  output wire        cpu_clk_en,
  output wire        osc_run,
  // Pin side
  input  wire        ext_prog_mem,
  input  wire [7:0]  core_port0_out,
  input  wire [7:0]  core_port0_oe,
  input  wire [7:0]  core_port0_latch,
  input  wire [7:0]  core_port2_out,
  input  wire [7:0]  core_port2_latch,
  input  wire        core_addr_latch_strobe,
  input  wire        core_prog_store_strobe,
  output reg  [7:0]  port0_out,
  output reg  [7:0]  port0_oe,
  output reg  [7:0]  port2_out,
  output reg         addr_latch_strobe,
  output reg         prog_store_strobe
);

  localparam ST_RUN  = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_DOWN = 2'd2;
  localparam ST_WAKE = 2'd3;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [1:0] power_control_reg;
  reg [7:0] irq_en_reg;
  reg [5:0] priority_upper_bits;
  reg [5:0] priority_lower_bits;
  reg [1:0] ext_edge_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] in_service_reg;
  reg [3:0] in_service_next;
  reg [1:0] vec_level_reg;
  reg [7:0] held_port2_reg;
  reg       wr_pend_reg;
  reg [9:0] wr_idx_reg;
  reg [1:0] pwr_hw_next;
  reg       cur_active;
  reg [1:0] cur_level;
  reg [31:0] rd_next;

  wire       ahb_take;
  wire       ack;
  wire       glob_en;
  wire       lowpower;
  wire [5:0] raw_req;
  wire [5:0] req_en;
  wire       arb_found;
  wire [2:0] arb_idx;
  wire [1:0] arb_level;
  wire       beats_cur;
  wire       valid_next;
  wire [1:0] x_req;
  wire [1:0] x_low;
  wire [1:0] x_rise;
  wire [1:0] x_en;
  wire [1:0] x_clear;
  wire [1:0] x_capture;
  wire       wake_low;
  wire       wake_rise;
  integer    k;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ahb_take  = hsel & hready & htrans[1];

  assign glob_en  = irq_en_reg[`EN_GLOBAL_BIT];
  assign lowpower = (state_reg != ST_RUN);
  assign ack      = irq_valid & irq_ack;

  // ----------------------------------------
  // External pins
  // ----------------------------------------
  assign x_en      = {irq_en_reg[`EXT1_SRC], irq_en_reg[`EXT0_SRC]} & {2{glob_en}};
  assign x_clear   = {ack & (irq_vector == `EXT1_SRC), ack & (irq_vector == `EXT0_SRC)};
  // Low-power fall is latched so a level pin is still served after release
  assign x_capture = ext_edge_reg | ({2{lowpower}} & x_en);

  ext_irq_detect u_ext0 (
    .core_clk   (core_clk),
    .reset      (reset),
    .pin_n      (ext_irq_zero),
    .edge_mode  (ext_edge_reg[0]),
    .capture_en (x_capture[0]),
    .clear      (x_clear[0]),
    .req        (x_req[0]),
    .low        (x_low[0]),
    .rise       (x_rise[0])
  );

  ext_irq_detect u_ext1 (
    .core_clk   (core_clk),
    .reset      (reset),
    .pin_n      (ext_irq_one),
    .edge_mode  (ext_edge_reg[1]),
    .capture_en (x_capture[1]),
    .clear      (x_clear[1]),
    .req        (x_req[1]),
    .low        (x_low[1]),
    .rise       (x_rise[1])
  );

  assign wake_low  = |(x_low & x_en);
  assign wake_rise = |(x_rise & x_en);

  // ----------------------------------------
  // Priority resolution
  // ----------------------------------------
  // Order: ext0, timer0, ext1, timer1, serial, timer2
  assign raw_req = {periph_irq[3], periph_irq[2], periph_irq[1],
                    x_req[1], periph_irq[0], x_req[0]};
  assign req_en  = raw_req & irq_en_reg[5:0] & {6{glob_en}};

  irq_arbiter #(.N(6)) u_arb (
    .req       (req_en),
    .lvl_upper (priority_upper_bits),
    .lvl_lower (priority_lower_bits),
    .found     (arb_found),
    .idx       (arb_idx),
    .level     (arb_level)
  );

  always @* begin
    cur_active = 1'b0;
    cur_level  = 2'h0;
    for (k = 0; k < 4; k = k + 1) begin
      if (in_service_reg[k]) begin
        cur_active = 1'b1;
        cur_level  = k[1:0];
      end
    end
  end

  // Level 3 can never be beaten, so it is never preempted
  assign beats_cur  = ~cur_active | (arb_level > cur_level);
  // Offer withdrawn for one cycle after an ack to let in-service settle
  assign valid_next = (state_reg == ST_RUN) & arb_found & beats_cur & ~ack;

  always @* begin
    in_service_next = in_service_reg;
    if (return_from_isr && cur_active) begin
      in_service_next[cur_level] = 1'b0;
    end
    if (ack) begin
      in_service_next[vec_level_reg] = 1'b1;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_valid      <= 1'b0;
      irq_vector     <= 3'h0;
      vec_level_reg  <= 2'h0;
      in_service_reg <= 4'h0;
    end else begin
      irq_valid      <= valid_next;
      in_service_reg <= in_service_next;
      if (!irq_valid || ack) begin
        irq_vector    <= arb_idx;
        vec_level_reg <= arb_level;
      end
    end
  end

  // ----------------------------------------
  // Power mode sequencing
  // ----------------------------------------
  always @* begin
    state_next   = state_reg;
    pwr_hw_next  = power_control_reg;
    case (state_reg)
      ST_RUN: begin
        // Power-down takes precedence when both bits are set
        if (power_control_reg[`PWR_DOWN_BIT]) begin
          state_next = ST_DOWN;
        end else if (power_control_reg[`PWR_IDLE_BIT]) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (arb_found) begin
          pwr_hw_next[`PWR_IDLE_BIT] = 1'b0;
          state_next = ST_RUN;
        end
      end
      ST_DOWN: begin
        if (wake_low) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_rise) begin
          pwr_hw_next  = 2'h0;
          state_next   = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cpu_clk_en = (state_reg == ST_RUN);
  assign osc_run    = (state_reg != ST_DOWN);

  // ----------------------------------------
  // Register file, AHB-Lite data phase
  // ----------------------------------------
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 10'h000;
    end else if (hready) begin
      wr_pend_reg <= ahb_take & hwrite;
      wr_idx_reg  <= haddr[11:2];
    end
  end

  // Interrupt exit only touches the power control bits; reset clears all
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      power_control_reg   <= `PWR_CTRL_RST;
      irq_en_reg          <= `IRQ_EN_RST;
      priority_upper_bits <= `PRIO_RST;
      priority_lower_bits <= `PRIO_RST;
      ext_edge_reg        <= `EXTCFG_RST;
    end else begin
      power_control_reg <= pwr_hw_next;
      if (wr_pend_reg) begin
        case (wr_idx_reg)
          `PWR_CTRL_IDX: power_control_reg  <= hwdata[1:0];
          `IRQ_EN_IDX:  irq_en_reg          <= hwdata[7:0];
          `PRIO_HI_IDX: priority_upper_bits <= hwdata[5:0];
          `PRIO_LO_IDX: priority_lower_bits <= hwdata[5:0];
          `EXTCFG_IDX:  ext_edge_reg        <= hwdata[1:0];
          default: begin
          end
        endcase
      end
    end
  end

  always @* begin
    rd_next = 32'h0000_0000;
    case (haddr[11:2])
      `PWR_CTRL_IDX: rd_next[1:0] = power_control_reg;
      `IRQ_EN_IDX:  rd_next[7:0] = irq_en_reg;
      `PRIO_HI_IDX: rd_next[5:0] = priority_upper_bits;
      `PRIO_LO_IDX: rd_next[5:0] = priority_lower_bits;
      `EXTCFG_IDX:  rd_next[1:0] = ext_edge_reg;
      `STATUS_IDX:  rd_next[11:0] = {x_req, irq_vector, irq_valid,
                                     in_service_reg, state_reg};
      default:      rd_next = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_take && !hwrite) begin
      hrdata <= rd_next;
    end
  end

  // ----------------------------------------
  // Pin states in low-power modes
  // ----------------------------------------
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      held_port2_reg    <= 8'hFF;
      port0_out         <= 8'h00;
      port0_oe          <= 8'h00;
      port2_out         <= 8'hFF;
      addr_latch_strobe <= 1'b1;
      prog_store_strobe <= 1'b1;
    end else if (!lowpower) begin
      held_port2_reg    <= core_port2_out;
      port0_out         <= core_port0_out;
      port0_oe          <= core_port0_oe;
      port2_out         <= core_port2_out;
      addr_latch_strobe <= core_addr_latch_strobe;
      prog_store_strobe <= core_prog_store_strobe;
    end else begin
      addr_latch_strobe <= (state_reg == ST_IDLE);
      prog_store_strobe <= (state_reg == ST_IDLE);
      port0_out         <= 8'h00;
      if (ext_prog_mem) begin
        port0_oe <= 8'h00;
      end else begin
        port0_oe <= ~core_port0_latch;
      end
      if (ext_prog_mem && (state_reg == ST_IDLE)) begin
        port2_out <= held_port2_reg;
      end else begin
        port2_out <= core_port2_latch;
      end
    end
  end

endmodule // lpm_irq_ctrl

// [cpu_model.sv]
`timescale 1ns/1ps

module cpu_model (
  input  wire       core_clk,
  input  wire       reset,
  input  wire       irq_valid,
  input  wire [3:0] ack_wait,
  output reg        irq_ack
);
  reg [3:0] wait_cnt_reg;

  // Ack ack_wait+1 cycles after irq_valid rises; one-cycle pulse, then dropped
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_ack      <= 1'b0;
      wait_cnt_reg <= 4'h0;
    end else if (irq_valid && !irq_ack) begin
      irq_ack      <= (wait_cnt_reg >= ack_wait);
      wait_cnt_reg <= wait_cnt_reg + 4'h1;
    end else begin
      irq_ack      <= 1'b0;
      wait_cnt_reg <= 4'h0;
    end
  end
endmodule // cpu_model

// [lpm_irq_ctrl_monitor.sv]
`timescale 1ns/1ps

module lpm_irq_ctrl_monitor (
  input wire       core_clk,
  input wire       reset,
  input wire       hreadyout,
  input wire       hresp,
  input wire       cpu_clk_en,
  input wire       osc_run,
  input wire       addr_latch_strobe,
  input wire       prog_store_strobe,
  input wire [7:0] port0_out,
  input wire [7:0] port0_oe,
  input wire       ext_prog_mem,
  input wire [7:0] core_port0_latch,
  input wire       irq_valid,
  input wire       irq_ack,
  input wire [2:0] irq_vector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_bus_always_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_down_gates_cpu: assert property (!osc_run |-> !cpu_clk_en)
    else $error("cpu clock runs with oscillator stopped");
  a_idle_strobes_high: assert property ($fell(cpu_clk_en) && osc_run
    |=> addr_latch_strobe && prog_store_strobe)
    else $error("strobes not high in idle");
  a_down_strobes_low: assert property (!$past(osc_run)
    |-> !addr_latch_strobe && !prog_store_strobe)
    else $error("strobes not low in power-down");
  a_port0_zero_only: assert property (!$past(cpu_clk_en) |-> port0_out == 8'h00
    && port0_oe == ($past(ext_prog_mem) ? 8'h00 : ~$past(core_port0_latch)))
    else $error("port0 drives a one in low power");
  a_offer_holds: assert property (irq_valid && !irq_ack
    |=> irq_valid && $stable(irq_vector))
    else $error("offered vector changed before ack");
  a_ack_retires: assert property (irq_valid && irq_ack |=> !irq_valid)
    else $error("offer still up after ack");
  a_vector_range: assert property (irq_valid |-> irq_vector <= 3'h5)
    else $error("vector out of range");
endmodule // lpm_irq_ctrl_monitor

bind lpm_irq_ctrl lpm_irq_ctrl_monitor u_mon (.*);

// [test_irq_priority_and_low_power_modes.sv]
`timescale 1ns/1ps
`include "lpm_irq_defs.vh"

module test_irq_priority_and_low_power_modes;
  reg        core_clk, reset, hsel, hwrite, ext_irq_zero, ext_irq_one;
  reg        return_from_isr, ext_prog_mem, core_addr_latch_strobe, core_prog_store_strobe;
  reg [31:0] haddr, hwdata, rdat;
  reg [1:0]  htrans;
  reg [3:0]  periph_irq, ack_wait;
  reg [7:0]  core_port0_out, core_port0_oe, core_port0_latch, core_port2_out, core_port2_latch;
  wire       hreadyout, hresp, irq_valid, irq_ack, cpu_clk_en, osc_run;
  wire       addr_latch_strobe, prog_store_strobe;
  wire [31:0] hrdata;
  wire [2:0] irq_vector;
  wire [7:0] port0_out, port0_oe, port2_out;
  wire       hready = hreadyout;
  wire [2:0] hsize = 3'h2;
  reg [2:0]  got[$];
  integer    mismatches, checked, i;

  lpm_irq_ctrl uut (.*);
  cpu_model u_cpu (.*);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (irq_valid && irq_ack) got.push_back(irq_vector);

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  task chk(input [31:0] s, input [31:0] e, input [63:0] nm);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask

  // Address phase held until hready, then data phase until hready
  task bus(input [9:0] idx, input w, input [31:0] wd);
    begin
      hsel <= 1'b1;
      haddr <= {20'h0, idx, 2'h0};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge core_clk);
      while (!hready) @(posedge core_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge core_clk);
      while (!hready) @(posedge core_clk);
      rdat = hrdata;
    end
  endtask

  task rc(input [9:0] idx, input [31:0] e, input [63:0] nm);
    begin
      bus(idx, 1'b0, 32'h0);
      chk(rdat, e, nm);
    end
  endtask

  task ret;
    begin
      return_from_isr <= 1'b1;
      @(posedge core_clk);
      return_from_isr <= 1'b0;
      tick(8);
    end
  endtask

  initial begin
    #20000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end

  initial begin
    {mismatches, checked} = 0;
    {reset, ext_irq_zero, ext_irq_one} = 3'h7;
    {hsel, hwrite, return_from_isr, ext_prog_mem} = 4'h0;
    {core_addr_latch_strobe, core_prog_store_strobe, haddr, hwdata, htrans} = 0;
    {periph_irq, ack_wait} = 8'h03;
    {core_port0_out, core_port0_oe, core_port0_latch} = 24'h3355A5;
    {core_port2_out, core_port2_latch} = 16'hA5C3;
    tick(5);
    reset <= 1'b0;
    @(posedge core_clk);
    rc(`PWR_CTRL_IDX, 32'h0, "pwr_ctrl");
    rc(`IRQ_EN_IDX, 32'h0, "irq_en");
    rc(`PRIO_HI_IDX, 32'h0, "prio_hi");
    rc(10'h001, 32'h0, "unmapped");
    bus(`IRQ_EN_IDX, 1'b1, 32'h3A);
    periph_irq <= 4'h7;
    tick(8);
    chk(got.size(), 0, "count");
    bus(`PRIO_HI_IDX, 1'b1, 32'h2A);
    bus(`PRIO_LO_IDX, 1'b1, 32'h31);
    rc(`PRIO_LO_IDX, 32'h31, "prio_lo");
    bus(`IRQ_EN_IDX, 1'b1, 32'hBA);
    tick(8);
    chk(got.size(), 1, "count");
    periph_irq <= 4'hE;
    tick(8);
    periph_irq <= 4'h6;
    ret;
    ret;
    periph_irq <= 4'h4;
    ret;
    periph_irq <= 4'h0;
    ret;
    for (i = 0; i < 4; i = i + 1)
      chk(got[i], (16'h4351 >> (4 * i)) & 7, "vector");
    ack_wait <= 4'h0;
    bus(`IRQ_EN_IDX, 1'b1, 32'h87);
    ext_prog_mem <= 1'b1;
    bus(`PWR_CTRL_IDX, 1'b1, 32'h1);
    tick(3);
    core_port2_out <= 8'h3C;
    tick(2);
    chk({osc_run, cpu_clk_en}, 2, "idle");
    chk({addr_latch_strobe, prog_store_strobe}, 3, "strobes");
    chk({port2_out, port0_oe}, 16'hA500, "ports");
    periph_irq <= 4'h1;
    tick(6);
    chk(cpu_clk_en, 1, "cpu_clk");
    chk(got[4], 1, "vector");
    rc(`PWR_CTRL_IDX, 32'h0, "pwr_ctrl");
    periph_irq <= 4'h0;
    ret;
    ext_prog_mem <= 1'b0;
    bus(`PWR_CTRL_IDX, 1'b1, 32'h3);
    tick(3);
    periph_irq <= 4'h1;
    tick(4);
    chk(osc_run, 0, "osc");
    chk({addr_latch_strobe, prog_store_strobe}, 0, "strobes");
    chk({port0_out, port0_oe}, 16'h005A, "port0");
    periph_irq <= 4'h0;
    ext_irq_one <= 1'b0;
    tick(3);
    chk({osc_run, cpu_clk_en}, 2, "wake");
    ext_irq_zero <= 1'b0;
    tick(2);
    ext_irq_one <= 1'b1;
    tick(6);
    chk(cpu_clk_en, 1, "cpu_clk");
    chk(got[5], 0, "vector");
    rc(`PWR_CTRL_IDX, 32'h0, "pwr_ctrl");
    rc(`PRIO_LO_IDX, 32'h31, "prio_lo");
    ext_irq_zero <= 1'b1;
    ret;
    ret;
    bus(`PWR_CTRL_IDX, 1'b1, 32'h2);
    tick(3);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    chk(osc_run, 1, "osc");
    rc(`IRQ_EN_IDX, 32'h0, "irq_en");
    // Edge mode must keep a short low pulse after the pin is back high
    bus(`EXTCFG_IDX, 1'b1, 32'h1);
    ext_irq_zero <= 1'b0;
    tick(1);
    ext_irq_zero <= 1'b1;
    tick(1);
    rc(`STATUS_IDX, 32'h400, "status");
    tally_and_finish;
  end
endmodule // test_irq_priority_and_low_power_modes
